/* include/option_cfg_pkg.sv */
/*
  Types for the option byte configuration decoder: decoded fields,
  the decoded configuration struct, the APB request and FSM states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package option_cfg_pkg;

  typedef enum logic [1:0] {
    VD_HIGH = 2'h0, VD_MEDIUM = 2'h1, VD_LOW = 2'h2, VD_OFF = 2'h3
  } vd_level_e;

  typedef enum logic [1:0] {
    SEC_0K5 = 2'h0, SEC_1K = 2'h1, SEC_2K = 2'h2, SEC_4K = 2'h3
  } sector_size_e;

  typedef enum logic [1:0] {
    OSC_RESONATOR = 2'h0, OSC_RESERVED = 2'h1, OSC_INTERNAL_RC = 2'h2, OSC_EXTERNAL = 2'h3
  } oscillator_type_e;

  typedef enum logic [2:0] {
    RNG_1_2MHZ = 3'h0, RNG_2_4MHZ = 3'h1, RNG_4_8MHZ = 3'h2, RNG_8_16MHZ = 3'h3, RNG_VLP = 3'h4
  } oscillator_range_e;

  typedef struct packed {
    logic              watchdog_reset_on_halt;
    logic              watchdog_hw_enabled;
    logic              low_voltage_detector_en;
    vd_level_e         voltage_detect_threshold;
    sector_size_e      sector_zero_size;
    logic              readout_protection;
    logic              write_protection;
    logic              port_c_interrupt_map;
    oscillator_type_e  oscillator_type;
    oscillator_range_e oscillator_range;
    logic              doubler_enable;
  } cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b001,
    ST_MEM_ERASE = 3'b010,
    ST_OPT_ERASE = 3'b100
  } erase_state_e;

endpackage

/* include/option_cfg_regs.svh */
/*
  Register offsets, option-byte field positions and shipped values
  for the option byte configuration decoder.
  Assumes inclusion by bare name from an include path.
*/
`ifndef OPTION_CFG_REGS_SVH
`define OPTION_CFG_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_OPT0       8'h00
`define OFS_OPT1       8'h04
`define OFS_CMD        8'h08
`define OFS_STATUS     8'h0C
`define OFS_ACTIVE     8'h10
`define OFS_MEM_ADDR   8'h14
`define OFS_MEM_DATA   8'h18

// ----------------------------------------
// option byte 0 fields
// ----------------------------------------
`define B0_WATCHDOG_RESET_ON_HALT    7
`define B0_WDG_TYPE    6
`define B0_VD_HI       5
`define B0_VD_LO       4
`define B0_SEC_HI      3
`define B0_SEC_LO      2
`define B0_ROP         1
`define B0_WP          0

// ----------------------------------------
// option byte 1 fields
// ----------------------------------------
`define B1_PORTC_MAP   7
`define B1_RESERVED    6
`define B1_OSC_HI      5
`define B1_OSC_LO      4
`define B1_RNG_HI      3
`define B1_RNG_LO      1
`define B1_DOUBLER_OFF 0

// ----------------------------------------
// values, command and status bits
// ----------------------------------------
`define OPT0_SHIPPED   8'hFC
`define OPT1_SHIPPED   8'hEF
`define ERASED_BYTE    8'hFF
`define CMD_ERASE_OPT  0
`define ST_BUSY        0
`define ST_REFUSED     1
`define ST_PROG        2
`define ST_MISUSE      3

`endif

/* verif/option_byte_config_decoder_bench.sv */
/*
  Bench for the option byte decoder: one flash part on the bus,
  four masked parts with fixed bytes for the decode tables.
  Assumes a 16-byte memory for short erase runs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "option_cfg_regs.svh"

module option_byte_config_decoder_bench;
  import option_cfg_pkg::*;
  localparam int          N = 4;
  localparam logic [15:0] ROMS [N] = '{16'h0042, 16'h9754, 16'h68E6, 16'hFEF1};
  logic        clk, nrst, prog_mode, halt_entry, watchdog_running, pready, pslverr;
  logic        cfg_valid, halt_rst, unsup, e;
  logic [5:0]  port_c_irq, v0, v1;
  logic [31:0] prdata, r;
  apb_req_s    req;
  cfg_s        cfg;
  cfg_s        rcfg [N];
  logic [N-1:0] rhalt, runsup;
  logic [5:0]  rv0 [N];
  logic [5:0]  rv1 [N];
  int          fail_count, comparisons, cycles, t0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  prog_tool tool (.clk(clk), .req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  option_byte_config_decoder #(.MEM_DEPTH(16)) dut (
    .clk(clk), .nrst(nrst), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_mode(prog_mode), .halt_entry(halt_entry), .watchdog_running(watchdog_running), .port_c_irq(port_c_irq),
    .cfg(cfg), .cfg_valid(cfg_valid), .watchdog_halt_reset(halt_rst), .first_vector_port_c(v0),
    .second_vector_port_c(v1), .clock_cfg_unsupported(unsup));

  for (genvar i = 0; i < N; i++) begin : rom
    option_byte_config_decoder #(.MEM_DEPTH(16), .MASKED_ROM(1'b1), .ROM_OPT0(ROMS[i][15:8]),
      .ROM_OPT1(ROMS[i][7:0])) dut (
      .clk(clk), .nrst(nrst), .apb_req('0), .prdata(), .pready(), .pslverr(),
      .prog_mode(prog_mode), .halt_entry(halt_entry), .watchdog_running(watchdog_running), .port_c_irq(port_c_irq),
      .cfg(rcfg[i]), .cfg_valid(), .watchdog_halt_reset(rhalt[i]), .first_vector_port_c(rv0[i]),
      .second_vector_port_c(rv1[i]), .clock_cfg_unsupported(runsup[i]));
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic cfg_s exp_cfg(logic [7:0] b0, logic [7:0] b1);
    cfg_s c;
    c.watchdog_reset_on_halt   = b0[7];
    c.watchdog_hw_enabled      = ~b0[6];
    c.low_voltage_detector_en  = (b0[5:4] != 2'h3);
    c.voltage_detect_threshold = vd_level_e'(b0[5:4]);
    c.sector_zero_size         = sector_size_e'(b0[3:2]);
    c.readout_protection       = b0[1];
    c.write_protection         = b0[0];
    c.port_c_interrupt_map     = b1[7];
    c.oscillator_type          = oscillator_type_e'(b1[5:4]);
    c.oscillator_range         = b1[3] ? RNG_VLP : oscillator_range_e'(b1[3:1]);
    c.doubler_enable           = ~b1[0];
    return c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // reads compare data only when no error is expected
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic experr);
    tool.xfer(w, a, d, r, e);
    if (!w && !experr) chk(r, d);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0; prog_mode = 1'b1; halt_entry = 1'b0; watchdog_running = 1'b0; port_c_irq = 6'h00;
    fail_count = 0; comparisons = 0; cycles = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, cfg_valid}, 32'h1);
    chk({16'h0, cfg}, {16'h0, exp_cfg(8'hFC, 8'hEF)});
    for (int i = 0; i < N; i++) begin
      chk({16'h0, rcfg[i]}, {16'h0, exp_cfg(ROMS[i][15:8], ROMS[i][7:0])});
      chk({31'h0, runsup[i]}, {31'h0, (i == 1 || i == 2)});
    end
    for (int run = 1; run >= 0; run--) begin
      @(posedge clk) halt_entry <= 1'b1; watchdog_running <= run[0]; port_c_irq <= 6'h2A;
      @(posedge clk);
      halt_entry <= 1'b0;
      @(negedge clk);
      chk({31'h0, halt_rst}, {31'h0, run[0]});
      chk({26'h0, v1}, 32'h2A);
      chk({26'h0, v0}, 32'h0);
      for (int i = 0; i < N; i++) begin
        chk({31'h0, rhalt[i]}, {31'h0, ROMS[i][15] && (run[0] || !ROMS[i][14])});
        chk({26'h0, rv0[i]}, ROMS[i][7] ? 32'h0 : 32'h2A);
        chk({26'h0, rv1[i]}, ROMS[i][7] ? 32'h2A : 32'h0);
      end
    end
    acc(1'b0, `OFS_OPT0, 32'hFC, 1'b0);
    acc(1'b0, 8'h1C, 32'h0, 1'b1);
    @(posedge clk) prog_mode <= 1'b0;
    acc(1'b0, `OFS_OPT0, 32'h0, 1'b1);
    @(posedge clk) prog_mode <= 1'b1;
    acc(1'b1, `OFS_MEM_ADDR, 32'h3, 1'b0);
    acc(1'b0, `OFS_MEM_DATA, 32'hFF, 1'b0);
    acc(1'b1, `OFS_MEM_DATA, 32'h5A, 1'b0);
    acc(1'b0, `OFS_MEM_DATA, 32'h5A, 1'b0);
    acc(1'b1, `OFS_OPT0, 32'hF2, 1'b0);
    acc(1'b0, `OFS_MEM_DATA, 32'h0, 1'b1);
    acc(1'b1, `OFS_MEM_DATA, 32'h00, 1'b0);
    acc(1'b0, `OFS_STATUS, 32'h6, 1'b0);
    acc(1'b1, `OFS_STATUS, 32'h2, 1'b0);
    acc(1'b0, `OFS_STATUS, 32'h4, 1'b0);
    acc(1'b1, `OFS_CMD, 32'h1, 1'b0);
    t0 = cycles;
    do tool.xfer(1'b0, `OFS_STATUS, 32'h0, r, e); while (r[0] === 1'b1 && cycles - t0 < 200);
    chk({31'h0, (cycles - t0 >= 16 && !r[0])}, 32'h1);
    acc(1'b0, `OFS_OPT0, 32'hFC, 1'b0);
    acc(1'b0, `OFS_MEM_DATA, 32'hFF, 1'b0);
    acc(1'b1, `OFS_OPT0, 32'hF1, 1'b0);
    acc(1'b1, `OFS_MEM_DATA, 32'h00, 1'b0);
    acc(1'b1, `OFS_OPT0, 32'hF0, 1'b0);
    acc(1'b1, `OFS_CMD, 32'h1, 1'b0);
    acc(1'b0, `OFS_STATUS, 32'h6, 1'b0);
    acc(1'b0, `OFS_OPT0, 32'hF1, 1'b0);
    acc(1'b0, `OFS_MEM_DATA, 32'hFF, 1'b0);
    acc(1'b1, `OFS_OPT1, 32'h3E, 1'b0);
    acc(1'b0, `OFS_OPT1, 32'h7E, 1'b0);
    chk({16'h0, cfg}, {16'h0, exp_cfg(8'hFC, 8'hEF)});
    end_of_test();
  end
endmodule

bind option_byte_config_decoder option_cfg_checker chk_i (
  .clk(clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prog_mode(prog_mode), .halt_entry(halt_entry), .watchdog_running(watchdog_running), .port_c_irq(port_c_irq),
  .cfg(cfg), .cfg_valid(cfg_valid), .watchdog_halt_reset(watchdog_halt_reset),
  .first_vector_port_c(first_vector_port_c), .second_vector_port_c(second_vector_port_c),
  .clock_cfg_unsupported(clock_cfg_unsupported));

`default_nettype wire

/* verif/option_cfg_checker.sv */
/*
  Port checker for the option byte configuration decoder.
  Assumes it is bound to every decoder instance, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module option_cfg_checker
  import option_cfg_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire apb_req_s    apb_req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        prog_mode,
  input wire logic        halt_entry,
  input wire logic        watchdog_running,
  input wire logic [5:0]  port_c_irq,
  input wire cfg_s        cfg,
  input wire logic        cfg_valid,
  input wire logic        watchdog_halt_reset,
  input wire logic [5:0]  first_vector_port_c,
  input wire logic [5:0]  second_vector_port_c,
  input wire logic        clock_cfg_unsupported
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  logic halt_due;
  assign halt_due = halt_entry && cfg.watchdog_reset_on_halt && (watchdog_running || cfg.watchdog_hw_enabled);

  sequence one_wait_s;
    !pready ##1 pready;
  endsequence

  apb_wait_a: assert property (apb_req.psel && !apb_req.penable |=> one_wait_s)
    else $error("access answer not after one wait state");
  apb_offline_a: assert property (apb_req.psel && !apb_req.penable && !prog_mode |=> one_wait_s ##0 pslverr)
    else $error("access outside programming mode not refused");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  halt_reset_a: assert property (cfg_valid && halt_due |=> watchdog_halt_reset)
    else $error("missing reset on halt entry");
  halt_quiet_a: assert property (cfg_valid && !halt_due |=> !watchdog_halt_reset)
    else $error("unexpected halt reset");
  cfg_hold_a: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg))
    else $error("configuration changed between resets");
  clock_flag_a: assert property (cfg_valid && $past(cfg_valid) |-> clock_cfg_unsupported ==
    (cfg.doubler_enable && (cfg.oscillator_type == OSC_INTERNAL_RC || cfg.oscillator_range != RNG_2_4MHZ)))
    else $error("clock flag wrong");
  route_first_a: assert property (cfg_valid && $past(cfg_valid) |->
    first_vector_port_c == (cfg.port_c_interrupt_map ? 6'h00 : $past(port_c_irq))) else $error("first vector wrong");
  route_second_a: assert property (cfg_valid && $past(cfg_valid) |->
    second_vector_port_c == (cfg.port_c_interrupt_map ? $past(port_c_irq) : 6'h00)) else $error("second vector wrong");
endmodule

`default_nettype wire

/* verif/prog_tool.sv */
/*
  Programming tool model: the APB master that reaches the option bytes.
  Assumes the caller keeps to one transfer at a time.
*/
`timescale 1ns/1ns
`default_nettype none
`include "option_cfg_regs.svh"

module prog_tool
  import option_cfg_pkg::*;
(
  input  wire logic        clk,
  output apb_req_s         req,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial req = '0;

  // ----------------------------------------
  // one transfer, held until pready is seen
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    logic [31:0] dv;
    dv = d;
    if (w && a == `OFS_OPT1) dv[`B1_RESERVED] = 1'b1;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dv};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req <= '0;
  endtask
endmodule

`default_nettype wire

/* verilog/option_byte_config_decoder.sv */
/*
  Option byte configuration decoder: nonvolatile option byte store,
  program memory array with read-out and write protection, erase
  sequencer, and the decoded configuration held from reset to reset.
  Assumes an APB master reached only through a programming tool, and
  watchdog, halt and port C interrupt signals synchronous to clk.
*/
// Notes on behaviour
// R1: halt entry with watchdog running gives reset only when byte 0 bit 7 set.
// R2: byte 0 bit 6 clear means watchdog always on, set means software enabled.
// R3: voltage field 11 off, 10 lowest, 01 medium, 00 highest threshold.
// R4: sector 0 size 0.5k, 1k, 2k, 4k; 4k only on factory parts.
// R5: read-out protection blocks memory reads and memory writes.
// R6: erasing options under read-out protection wipes memory first.
// R7: write protection refuses every erase and program, itself included; the code still accepts option byte 1 writes.
// R8: port C interrupts go to second vector when bit set, else first.
// R9: the programmer keeps the reserved bit of byte 1 at default.
// R10: oscillator type 00 resonator, 01 reserved, 10 internal RC, 11 external.
// R11: range 1xx very low power, 000 to 011 from 1 MHz up to 16 MHz.
// R12: multiplier bit clear enables the frequency doubler.
// R13: doubler must not be used with the internal RC oscillator.
// R14: doubler only allowed with the 2 to 4 MHz range.
// R15: option bytes unmapped; reachable only in programming mode.
// R16: unprogrammed memory reads as all ones.
// R17: flash parts ship with the internal RC oscillator selected.
// R18: masked parts take fixed option values, nothing programmable.
// R19: options sampled after reset, decoded outputs held until next reset.
`timescale 1ns/1ns
`default_nettype none
`include "option_cfg_regs.svh"

module option_byte_config_decoder
  import option_cfg_pkg::*;
#(
  parameter int         MEM_DEPTH     = 4096,
  parameter bit         MASKED_ROM    = 1'b0,
  parameter bit         FACTORY_FLASH = 1'b0,
  parameter logic [7:0] ROM_OPT0      = 8'hFC,
  parameter logic [7:0] ROM_OPT1      = 8'hEF
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire apb_req_s    apb_req,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prog_mode,
  input  wire logic        halt_entry,
  input  wire logic        watchdog_running,
  input  wire logic [5:0]  port_c_irq,
  output cfg_s             cfg,
  output logic             cfg_valid,
  output logic             watchdog_halt_reset,
  output logic [5:0]       first_vector_port_c,
  output logic [5:0]       second_vector_port_c,
  output logic             clock_cfg_unsupported
);

  localparam int AW = $clog2(MEM_DEPTH);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_n;

  reset_release u_reset_release (
    .clk   (clk),
    .nrst  (nrst),
    .rst_n (rst_n)
  );

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [7:0]   opt0_reg;
  logic [7:0]   opt1_reg;
  logic [7:0]   mem [MEM_DEPTH];
  logic [AW-1:0] mem_addr_reg;
  logic [AW-1:0] erase_idx_reg;
  erase_state_e state_reg;
  erase_state_e state_next;
  logic         refused_reg;
  logic         captured_reg;
  logic [7:0]   active0_reg;
  logic [7:0]   active1_reg;

  // ----------------------------------------
  // effective option bytes
  // ----------------------------------------
  logic [7:0] eff0;
  logic [7:0] eff1;
  cfg_s       dec;

  // masked parts ignore the store entirely
  assign eff0 = MASKED_ROM ? ROM_OPT0 : opt0_reg; // see R18
  assign eff1 = MASKED_ROM ? ROM_OPT1 : opt1_reg; // see R18

  option_decode u_option_decode (
    .byte0 (eff0),
    .byte1 (eff1),
    .cfg   (dec)
  );

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic access;
  logic done;
  logic busy;
  logic rop;
  logic wp;
  logic hit_opt0;
  logic hit_opt1;
  logic hit_cmd;
  logic hit_status;
  logic hit_active;
  logic hit_maddr;
  logic hit_mdata;
  logic mapped;

  assign access     = apb_req.psel & apb_req.penable;
  assign done       = access & pready;
  assign busy       = (state_reg != ST_IDLE);
  assign rop        = eff0[`B0_ROP];
  assign wp         = eff0[`B0_WP];
  assign hit_opt0   = (apb_req.paddr == `OFS_OPT0);
  assign hit_opt1   = (apb_req.paddr == `OFS_OPT1);
  assign hit_cmd    = (apb_req.paddr == `OFS_CMD);
  assign hit_status = (apb_req.paddr == `OFS_STATUS);
  assign hit_active = (apb_req.paddr == `OFS_ACTIVE);
  assign hit_maddr  = (apb_req.paddr == `OFS_MEM_ADDR);
  assign hit_mdata  = (apb_req.paddr == `OFS_MEM_DATA);
  assign mapped     = hit_opt0 | hit_opt1 | hit_cmd | hit_status
                    | hit_active | hit_maddr | hit_mdata;

  // ----------------------------------------
  // write effects
  // ----------------------------------------
  logic wr;
  logic wr_opt0;
  logic wr_opt1;
  logic wr_erase;
  logic wr_mem;
  logic bad_opt0;
  logic bad_opt1;
  logic bad_erase;
  logic bad_mem;
  logic refuse;
  logic sec_4k_illegal;

  // outside programming mode nothing here is reachable at all
  assign wr = done & apb_req.pwrite & prog_mode; // see R15

  assign sec_4k_illegal = ~FACTORY_FLASH
                        & (apb_req.pwdata[`B0_SEC_HI:`B0_SEC_LO] == 2'h3); // see R4

  assign bad_opt0  = MASKED_ROM | wp | busy | sec_4k_illegal; // see R7
  assign bad_opt1  = MASKED_ROM | busy;
  assign bad_erase = MASKED_ROM | wp | busy; // see R7
  // memory programming blocked by both protections
  assign bad_mem   = MASKED_ROM | wp | rop | busy; // see R5 see R7

  assign wr_opt0  = wr & hit_opt0 & ~bad_opt0;
  assign wr_opt1  = wr & hit_opt1 & ~bad_opt1;
  assign wr_erase = wr & hit_cmd & apb_req.pwdata[`CMD_ERASE_OPT] & ~bad_erase;
  assign wr_mem   = wr & hit_mdata & ~bad_mem;

  assign refuse = wr & ((hit_opt0 & bad_opt0)
                      | (hit_opt1 & bad_opt1)
                      | (hit_cmd & apb_req.pwdata[`CMD_ERASE_OPT] & bad_erase)
                      | (hit_mdata & bad_mem));

  // ----------------------------------------
  // erase sequencer
  // ----------------------------------------
  logic last_idx;

  assign last_idx = (erase_idx_reg == AW'(MEM_DEPTH - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (wr_erase) begin
          // protected memory must be gone before the options reopen
          state_next = rop ? ST_MEM_ERASE : ST_OPT_ERASE; // see R6
        end
      end
      ST_MEM_ERASE: begin
        if (last_idx) begin
          state_next = ST_OPT_ERASE; // see R6
        end
      end
      ST_OPT_ERASE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_idx_reg <= '0;
    end else if (state_reg == ST_MEM_ERASE) begin
      erase_idx_reg <= erase_idx_reg + AW'(1);
    end else begin
      erase_idx_reg <= '0;
    end
  end

  // ----------------------------------------
  // option byte store
  // ----------------------------------------
  // nrst stands for power-on here: the store starts at the shipped value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt0_reg <= `OPT0_SHIPPED; // see R17
      opt1_reg <= `OPT1_SHIPPED; // see R17
    end else if (state_reg == ST_OPT_ERASE) begin
      // erase returns to shipped values, not all ones, so the part
      // does not lock itself again under read-out protection
      opt0_reg <= `OPT0_SHIPPED; // see R6
      opt1_reg <= `OPT1_SHIPPED;
    end else begin
      if (wr_opt0) begin
        opt0_reg <= apb_req.pwdata[7:0];
      end
      if (wr_opt1) begin
        // reserved bit is held at its default whatever is written
        opt1_reg <= {apb_req.pwdata[`B1_PORTC_MAP],
                     opt1_reg[`B1_RESERVED],
                     apb_req.pwdata[`B1_OSC_HI:0]}; // see R9
      end
    end
  end

  // ----------------------------------------
  // program memory
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= `ERASED_BYTE; // see R16
      end
    end else if (state_reg == ST_MEM_ERASE) begin
      mem[erase_idx_reg] <= `ERASED_BYTE; // see R6 see R16
    end else if (wr_mem) begin
      // flash programming can only clear bits
      mem[mem_addr_reg] <= mem[mem_addr_reg] & apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_reg <= '0;
    end else if (wr & hit_maddr) begin
      mem_addr_reg <= apb_req.pwdata[AW-1:0];
    end
  end

  // ----------------------------------------
  // refused flag, write one to clear, set wins
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_reg <= 1'b0;
    end else if (refuse) begin
      refused_reg <= 1'b1;
    end else if (wr & hit_status & apb_req.pwdata[`ST_REFUSED]) begin
      refused_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // read path, one wait state
  // ----------------------------------------
  logic [7:0]  rd_byte;
  logic        rd_err;
  logic        mem_read_blocked;

  assign mem_read_blocked = rop & ~apb_req.pwrite; // see R5

  always_comb begin
    rd_byte = 8'h00;
    rd_err  = 1'b0;
    if (!prog_mode || !mapped) begin
      rd_err = 1'b1; // see R15
    end else if (hit_opt0) begin
      rd_byte = eff0;
    end else if (hit_opt1) begin
      rd_byte = eff1;
    end else if (hit_status) begin
      rd_byte = {4'h0, clock_cfg_unsupported, prog_mode, refused_reg, busy};
    end else if (hit_active) begin
      rd_byte = active0_reg;
    end else if (hit_maddr) begin
      rd_byte = 8'(mem_addr_reg);
    end else if (hit_mdata) begin
      if (mem_read_blocked) begin
        rd_err = 1'b1; // see R5
      end else begin
        rd_byte = mem[mem_addr_reg];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      pslverr <= rd_err;
      prdata  <= (apb_req.pwrite || rd_err) ? 32'h0000_0000
               : (hit_active ? {16'h0000, active1_reg, rd_byte}
                             : {24'h00_0000, rd_byte});
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // configuration captured once per reset
  // ----------------------------------------
  // later programming reaches cfg only after the next reset; rop and wp follow the store at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_reg <= 1'b0;
      cfg          <= '0;
      active0_reg  <= 8'h00;
      active1_reg  <= 8'h00;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1; // see R19
      cfg          <= dec;  // see R3 see R4 see R10 see R11 see R12
      active0_reg  <= eff0;
      active1_reg  <= eff1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_valid <= 1'b0;
    end else begin
      cfg_valid <= captured_reg;
    end
  end

  // ----------------------------------------
  // run-time effects of the held configuration
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_halt_reset <= 1'b0;
    end else begin
      // a hardware watchdog counts as running from reset on
      watchdog_halt_reset <= cfg_valid & halt_entry & cfg.watchdog_reset_on_halt
                           & (watchdog_running | cfg.watchdog_hw_enabled); // see R1 see R2
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_vector_port_c  <= 6'h00;
      second_vector_port_c <= 6'h00;
    end else begin
      first_vector_port_c  <= cfg.port_c_interrupt_map ? 6'h00 : port_c_irq; // see R8
      second_vector_port_c <= cfg.port_c_interrupt_map ? port_c_irq : 6'h00; // see R8
    end
  end

  // flags a doubler setting the clock unit is not guaranteed to handle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_cfg_unsupported <= 1'b0;
    end else begin
      clock_cfg_unsupported <= cfg_valid & cfg.doubler_enable
                             & ((cfg.oscillator_type == OSC_INTERNAL_RC)
                              | (cfg.oscillator_range != RNG_2_4MHZ)); // see R13 see R14
    end
  end

endmodule

`default_nettype wire

/* verilog/option_decode.sv */
/*
  Pure decode of the two option bytes into the configuration struct.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
`include "option_cfg_regs.svh"

module option_decode
  import option_cfg_pkg::*;
(
  input  wire logic [7:0] byte0,
  input  wire logic [7:0] byte1,
  output cfg_s            cfg
);

  always_comb begin
    cfg.watchdog_reset_on_halt   = byte0[`B0_WATCHDOG_RESET_ON_HALT];
    cfg.watchdog_hw_enabled      = ~byte0[`B0_WDG_TYPE];
    cfg.low_voltage_detector_en  = (byte0[`B0_VD_HI:`B0_VD_LO] != 2'h3);
    cfg.voltage_detect_threshold = vd_level_e'(byte0[`B0_VD_HI:`B0_VD_LO]);
    cfg.sector_zero_size         = sector_size_e'(byte0[`B0_SEC_HI:`B0_SEC_LO]);
    cfg.readout_protection       = byte0[`B0_ROP];
    cfg.write_protection         = byte0[`B0_WP];
    cfg.port_c_interrupt_map     = byte1[`B1_PORTC_MAP];
    cfg.oscillator_type          = oscillator_type_e'(byte1[`B1_OSC_HI:`B1_OSC_LO]);
    // top range bit set means very low power whatever the low two bits say
    if (byte1[`B1_RNG_HI]) begin
      cfg.oscillator_range = RNG_VLP;
    end else begin
      cfg.oscillator_range = oscillator_range_e'({1'b0, byte1[`B1_RNG_HI-1:`B1_RNG_LO]});
    end
    cfg.doubler_enable = ~byte1[`B1_DOUBLER_OFF];
  end

endmodule

`default_nettype wire

/* verilog/reset_release.sv */
/*
  Reset release: asynchronous assertion, release through two flops.
  Assumes nrst is active low and may arrive at any time.
*/
`timescale 1ns/1ns
`default_nettype none

module reset_release (
  input  wire logic clk,
  input  wire logic nrst,
  output logic      rst_n
);

  logic hold_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      hold_reg <= 1'b1;
      rst_n    <= hold_reg;
    end
  end

endmodule

`default_nettype wire
